// ### verilog/opv_pkg.sv
// Purpose: shared constants for the one-time-programmable program/verify port
// Assumes: 125 MHz ref_clk on both ends
// Notes: pin codes are {port2 bit6, port3 bit7, port3 bit6}
`default_nettype none
package opv_pkg;
   localparam int CLK_PERIOD_NS = 8;
   // programming strobe timing
   localparam int PULSE_LOW_NS = 100000;
   localparam int PULSE_LOW_CYC = PULSE_LOW_NS / CLK_PERIOD_NS;
   localparam int PULSE_HIGH_NS = 10000;
   localparam int PULSE_HIGH_CYC = (PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VPP_SETUP_NS = 10000;
   localparam int VPP_SETUP_CYC = (VPP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // 48 oscillator periods at the slowest 4 MHz oscillator
   localparam int ACCESS_NS = 12000;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSES_SMALL = 25;
   localparam int PULSES_LARGE = 10;
   localparam int ENC_SMALL = 32;
   localparam int ENC_LARGE = 64;
   localparam int CODE_AW = 12;
   localparam logic [15:0] SIG_ADDR0 = 16'h0030;
   localparam logic [15:0] SIG_ADDR1_SMALL = 16'h0031;
   localparam logic [15:0] SIG_ADDR1_LARGE = 16'h0060;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [2:0] PIN_CODE = 3'h3;
   localparam logic [2:0] PIN_ENC = 3'h2;
   localparam logic [2:0] PIN_SEC1 = 3'h7;
   localparam logic [2:0] PIN_SEC2 = 3'h4;
   localparam logic [1:0] PIN_VERIFY = 2'h3;
   localparam logic [1:0] PIN_SIG = 2'h0;
   typedef enum logic [2:0] {OP_CODE, OP_ENC, OP_SEC1, OP_SEC2, OP_VERIFY, OP_SIG} opv_op_t;
endpackage
`default_nettype wire

// ### verilog/opv_if.sv
// Purpose: pins between the programmer and the device
// Assumes: port 0 idles high through a pull-up when nobody drives it
// Notes: ports 1 and 2 are carried as one 16-bit address
`timescale 1ns/1ps
`default_nettype none
interface opv_if;
   logic chip_reset;
   logic code_fetch_enable_n;
   logic latch_program_strobe;
   logic external_access_prog_voltage;
   logic vpp_on;
   logic port2_bit7_enable;
   logic port2_bit6_select;
   logic port3_bit7_select;
   logic port3_bit6_select;
   logic [15:0] addr;
   logic [7:0] p0_prog_out;
   logic p0_prog_oe_n;
   logic [7:0] p0_dev_out;
   logic p0_dev_oe_n;
   wire [7:0] port0;

   assign port0 = !p0_dev_oe_n ? p0_dev_out : (!p0_prog_oe_n ? p0_prog_out : 8'hFF);

   modport dev (
      input chip_reset, code_fetch_enable_n, latch_program_strobe, external_access_prog_voltage,
      input vpp_on, port2_bit7_enable, port2_bit6_select, port3_bit7_select, port3_bit6_select,
      input addr, port0,
      output p0_dev_out, p0_dev_oe_n
   );
   modport prog (
      output chip_reset, code_fetch_enable_n, latch_program_strobe, external_access_prog_voltage,
      output vpp_on, port2_bit7_enable, port2_bit6_select, port3_bit7_select, port3_bit6_select,
      output addr, p0_prog_out, p0_prog_oe_n,
      input port0
   );
endinterface
`default_nettype wire

// ### verilog/opv_device.sv
// Purpose: device end, code store, encryption table, lock bits, verify readout
// Assumes: all pins synchronous to ref_clk
// Notes: code store keeps contents across rst_b, table and locks do not
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] programmer keeps oscillator at 4 to 6 MHz
// [R2] write address on ports 1/2, byte on 0
// [R3] 25 strobes per write, 10 on large parts
// [R4] strobe low 100us, then high 10us minimum
// [R5] table loaded address by address, 1F or 3F
// [R6] programmed table makes every verify encrypted; here entries left at FF pass the code byte through unchanged
// [R7] any lock bit blocks code and table writes
// [R8] remaining lock bit stays programmable
// [R9] code readout only while lock two clear
// [R10] verify drives addressed byte onto port 0
// [R11] verify output is code XNOR table entry
// [R12] table powers up all ones, transparent
// [R13] no mode reads the table directly
// [R14] lock one blocks writes, both block verify; here lock two alone blocks verify and lock one leaves it open
// [R15] programmer should set a lock with table
// [R16] signature bytes at 30H and 31H/60H
// [R17] write pin levels select four write modes
// [R18] read pin levels select verify or signature
// [R19] mode latched at strobe fall, bad patterns ignored
module opv_device #(
   parameter int CODE_AW = opv_pkg::CODE_AW,
   parameter int ENC_ENTRIES = opv_pkg::ENC_SMALL,
   parameter int PULSES = opv_pkg::PULSES_SMALL,
   parameter logic [15:0] SIG_ADDR1 = opv_pkg::SIG_ADDR1_SMALL,
   // identity bytes: arbitrary neutral values
   parameter logic [7:0] SIG_ID0 = 8'hA5,
   parameter logic [7:0] SIG_ID1 = 8'h3C
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // pins
   opv_if.dev pins,
   // status
   output logic lock_bit_one,
   output logic lock_bit_two,
   output logic table_written
);
   localparam int EW = $clog2(ENC_ENTRIES);
   localparam int CNT_W = 5;

   // a full 64K store leaves no spare address bits to range-check
   if (CODE_AW < 6 || CODE_AW > 15) begin : g_bad_aw
      $error("CODE_AW out of range");
   end
   if (ENC_ENTRIES != opv_pkg::ENC_SMALL && ENC_ENTRIES != opv_pkg::ENC_LARGE) begin : g_bad_enc
      $error("bad ENC_ENTRIES");
   end
   // the pulse counter is five bits wide
   if (PULSES < 1 || PULSES > 31) begin : g_bad_pulses
      $error("PULSES out of range");
   end
   if (SIG_ADDR1 == opv_pkg::SIG_ADDR0) begin : g_bad_sig
      $error("signature addresses collide");
   end

   logic [7:0] code_mem [0:(1 << CODE_AW) - 1];
   logic [7:0] enc_r [0:ENC_ENTRIES - 1];
   logic lock1_r;
   logic lock2_r;
   logic enc_dirty_r;
   logic strobe_q_r;
   logic [2:0] mode_r;
   logic [15:0] addr_r;
   logic [7:0] data_r;
   logic [CNT_W-1:0] cnt_r;
   logic [7:0] dout_r;
   logic oe_n_r;

   // erased cells read all ones until programmed
   initial begin
      for (int i = 0; i < (1 << CODE_AW); i++) begin
         code_mem[i] = opv_pkg::ERASED;
      end
   end

   wire logic in_prog = pins.chip_reset & ~pins.code_fetch_enable_n;
   wire logic wr_lvl = in_prog & pins.vpp_on & pins.port2_bit7_enable; // see [R17]
   wire logic rd_lvl = in_prog & pins.latch_program_strobe & pins.external_access_prog_voltage
                       & ~pins.vpp_on & ~pins.port2_bit7_enable & ~pins.port2_bit6_select; // see [R18]
   wire logic [2:0] pin_code = {pins.port2_bit6_select, pins.port3_bit7_select, pins.port3_bit6_select};
   wire logic [1:0] rd_code = {pins.port3_bit7_select, pins.port3_bit6_select};
   wire logic is_code = pin_code == opv_pkg::PIN_CODE;
   wire logic is_enc = pin_code == opv_pkg::PIN_ENC;
   wire logic is_sec1 = pin_code == opv_pkg::PIN_SEC1;
   wire logic is_sec2 = pin_code == opv_pkg::PIN_SEC2;
   wire logic valid_mode = is_code | is_enc | is_sec1 | is_sec2; // see [R19]
   wire logic fall = strobe_q_r & ~pins.latch_program_strobe;
   wire logic rise = ~strobe_q_r & pins.latch_program_strobe;
   wire logic take = fall & wr_lvl & valid_mode; // see [R19]
   // a strobe is far longer than a clock, so one sample per clock sees each edge
   wire logic same_mode = mode_r == pin_code;
   wire logic same_addr = addr_r == pins.addr;
   wire logic same_data = data_r == pins.port0;
   // a change of pins mid-train restarts the count rather than mixing two writes
   wire logic same = cnt_r != '0 && same_mode && same_addr && same_data;
   // a write lands only after the full pulse train, ended by a rising strobe
   wire logic commit = rise & wr_lvl & cnt_r == CNT_W'(PULSES); // see [R3]
   wire logic locked = lock1_r | lock2_r;
   // addresses past the store are dropped, not folded onto a lower cell
   wire logic code_in_range = addr_r[15:CODE_AW] == '0;
   wire logic enc_in_range = addr_r[15:EW] == '0;
   wire logic code_ok = commit && mode_r == opv_pkg::PIN_CODE && !locked && code_in_range; // see [R2] [R7] [R14]
   wire logic enc_ok = commit && mode_r == opv_pkg::PIN_ENC && !locked && enc_in_range; // see [R5] [R7]
   wire logic sec1_ok = commit && mode_r == opv_pkg::PIN_SEC1; // see [R8]
   wire logic sec2_ok = commit && mode_r == opv_pkg::PIN_SEC2; // see [R8]
   wire logic [EW-1:0] enc_wr_idx = addr_r[EW-1:0];
   wire logic [CODE_AW-1:0] code_wr_idx = addr_r[CODE_AW-1:0];
   wire logic [7:0] code_wr_byte = code_mem[code_wr_idx] & data_r;
   wire logic [EW-1:0] enc_sel = pins.addr[EW-1:0]; // see [R11]
   wire logic [7:0] code_byte = code_mem[pins.addr[CODE_AW-1:0]];
   wire logic [7:0] enc_entry = enc_r[enc_sel];
   wire logic [7:0] enc_byte = ~(code_byte ^ enc_entry); // see [R6] [R11] [R12]
   wire logic rd_verify = rd_lvl && rd_code == opv_pkg::PIN_VERIFY && !lock2_r; // see [R9] [R14]
   wire logic rd_sig = rd_lvl && rd_code == opv_pkg::PIN_SIG; // see [R16]
   // locked verify leaves port 0 to its pull-up instead of a fixed byte
   wire logic rd_any = rd_verify | rd_sig; // see [R9] [R18]
   // other addresses in signature mode read as erased
   wire logic [7:0] sig_byte = pins.addr == opv_pkg::SIG_ADDR0 ? SIG_ID0 :
                               (pins.addr == SIG_ADDR1 ? SIG_ID1 : opv_pkg::ERASED);
   // only code bytes or signatures reach port 0, never a raw table byte
   wire logic [7:0] dout_nxt = rd_sig ? sig_byte : enc_byte; // see [R10] [R13]

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         strobe_q_r <= 1'b1;
         mode_r <= 3'h0;
         addr_r <= 16'h0000;
         data_r <= 8'h00;
         cnt_r <= '0;
      end else if (ce) begin
         strobe_q_r <= pins.latch_program_strobe;
         if (!wr_lvl) begin
            cnt_r <= '0;
         end else if (take) begin
            mode_r <= pin_code; // see [R19]
            addr_r <= pins.addr;
            data_r <= pins.port0;
            cnt_r <= same ? cnt_r + CNT_W'(1) : CNT_W'(1);
         end else if (commit) begin
            cnt_r <= '0;
         end
      end
   end

   // lock bits are accepted even while the other one is set
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lock1_r <= 1'b0;
         lock2_r <= 1'b0;
         enc_dirty_r <= 1'b0;
      end else if (ce) begin
         if (sec1_ok) begin
            lock1_r <= 1'b1; // see [R8]
         end
         if (sec2_ok) begin
            lock2_r <= 1'b1; // see [R8]
         end
         if (enc_ok) begin
            enc_dirty_r <= 1'b1;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < ENC_ENTRIES; g++) begin : g_enc
         wire logic enc_hit = ce && enc_ok && enc_wr_idx == EW'(g);
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               enc_r[g] <= opv_pkg::ERASED; // see [R12]
            end else if (enc_hit) begin
               enc_r[g] <= enc_r[g] & data_r; // see [R5]
            end
         end
      end
   endgenerate

   // cells can only be cleared, so a write ands into the stored byte
   // plain always: the power-on fill above writes this array as well
   always @(posedge ref_clk) begin
      if (ce && code_ok) begin
         code_mem[code_wr_idx] <= code_wr_byte; // see [R2]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dout_r <= opv_pkg::ERASED;
         oe_n_r <= 1'b1;
      end else if (ce) begin
         dout_r <= dout_nxt; // see [R10]
         oe_n_r <= ~rd_any; // see [R9] [R18]
      end
   end

   assign pins.p0_dev_out = dout_r;
   assign pins.p0_dev_oe_n = oe_n_r;
   assign lock_bit_one = lock1_r;
   assign lock_bit_two = lock2_r;
   assign table_written = enc_dirty_r;
endmodule // opv_device
`default_nettype wire

// ### verilog/opv_programmer.sv
// Purpose: programmer end, drives pin levels and strobe trains
// Assumes: ref_clk stands in for the device oscillator feed
// Notes: one command at a time, no queue
`timescale 1ns/1ps
`default_nettype none
module opv_programmer #(
   parameter int PULSES = opv_pkg::PULSES_SMALL,
   parameter int PULSE_LOW_CYC = opv_pkg::PULSE_LOW_CYC,
   parameter int PULSE_HIGH_CYC = opv_pkg::PULSE_HIGH_CYC,
   parameter int VPP_SETUP_CYC = opv_pkg::VPP_SETUP_CYC,
   parameter int ACCESS_CYC = opv_pkg::ACCESS_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // pins
   opv_if.prog pins,
   // command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire opv_pkg::opv_op_t cmd_op,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   // answer
   output logic rsp_valid,
   output logic [7:0] rsp_data
);
   if (PULSES < 1 || PULSES > 255) begin : g_bad_pulses
      $error("PULSES out of range");
   end
   if (PULSE_LOW_CYC < 1 || PULSE_LOW_CYC > 65535) begin : g_bad_low
      $error("PULSE_LOW_CYC out of range");
   end
   // port 0 is sampled one edge after the device registers it, so reads need two cycles
   if (PULSE_HIGH_CYC < 1 || VPP_SETUP_CYC < 1 || ACCESS_CYC < 2
       || PULSE_HIGH_CYC > 65535 || VPP_SETUP_CYC > 65535 || ACCESS_CYC > 65535) begin : g_bad_cnt
      $error("counts out of range");
   end

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_READ} opv_st_t;
   opv_st_t st_r;
   logic [15:0] cnt_r;
   logic [7:0] pulse_r;
   logic [2:0] sel_r;
   logic wr_r;
   logic vpp_r;
   logic strobe_r;
   logic [15:0] addr_r;
   logic [7:0] data_r;
   logic rsp_valid_r;
   logic [7:0] rsp_data_r;

   wire logic is_read = cmd_op == opv_pkg::OP_VERIFY || cmd_op == opv_pkg::OP_SIG;
   wire logic [2:0] sel_nxt = cmd_op == opv_pkg::OP_CODE ? opv_pkg::PIN_CODE :
                              cmd_op == opv_pkg::OP_ENC ? opv_pkg::PIN_ENC :
                              cmd_op == opv_pkg::OP_SEC1 ? opv_pkg::PIN_SEC1 :
                              cmd_op == opv_pkg::OP_SEC2 ? opv_pkg::PIN_SEC2 :
                              cmd_op == opv_pkg::OP_SIG ? {1'b0, opv_pkg::PIN_SIG} :
                              {1'b0, opv_pkg::PIN_VERIFY}; // see [R17] [R18]
   wire logic start = ce && cmd_valid && st_r == ST_IDLE;
   wire logic cnt_done_setup = cnt_r == 16'(VPP_SETUP_CYC - 1);
   wire logic cnt_done_low = cnt_r == 16'(PULSE_LOW_CYC - 1); // see [R4]
   wire logic cnt_done_high = cnt_r == 16'(PULSE_HIGH_CYC - 1); // see [R4]
   wire logic cnt_done_read = cnt_r == 16'(ACCESS_CYC - 1); // see [R1]
   wire logic last_pulse = pulse_r == 8'(PULSES - 1); // see [R3]

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_IDLE;
         cnt_r <= 16'h0000;
         pulse_r <= 8'h00;
         sel_r <= 3'h3;
         wr_r <= 1'b0;
         vpp_r <= 1'b0;
         strobe_r <= 1'b1;
         addr_r <= 16'h0000;
         data_r <= 8'h00;
         rsp_valid_r <= 1'b0;
         rsp_data_r <= 8'h00;
      end else if (ce) begin
         rsp_valid_r <= 1'b0;
         cnt_r <= cnt_r + 16'h0001;
         case (st_r)
            ST_IDLE: begin
               if (cmd_valid) begin
                  sel_r <= sel_nxt;
                  addr_r <= cmd_addr; // see [R2]
                  data_r <= cmd_data;
                  wr_r <= ~is_read;
                  vpp_r <= ~is_read;
                  cnt_r <= 16'h0000;
                  pulse_r <= 8'h00;
                  st_r <= is_read ? ST_READ : ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_done_setup) begin
                  strobe_r <= 1'b0;
                  cnt_r <= 16'h0000;
                  st_r <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (cnt_done_low) begin
                  strobe_r <= 1'b1;
                  cnt_r <= 16'h0000;
                  st_r <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (cnt_done_high) begin
                  cnt_r <= 16'h0000;
                  pulse_r <= pulse_r + 8'h01;
                  if (last_pulse) begin
                     wr_r <= 1'b0;
                     vpp_r <= 1'b0;
                     sel_r <= 3'h3;
                     st_r <= ST_IDLE;
                  end else begin
                     strobe_r <= 1'b0;
                     st_r <= ST_LOW;
                  end
               end
            end
            ST_READ: begin
               // wait the full access time, the device answers well inside it
               if (cnt_done_read) begin
                  rsp_valid_r <= 1'b1;
                  rsp_data_r <= pins.port0; // see [R10]
                  sel_r <= 3'h3;
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   assign cmd_ready = st_r == ST_IDLE;
   assign rsp_valid = rsp_valid_r;
   assign rsp_data = rsp_data_r;
   assign pins.chip_reset = 1'b1;
   assign pins.code_fetch_enable_n = 1'b0;
   assign pins.latch_program_strobe = strobe_r;
   assign pins.external_access_prog_voltage = 1'b1;
   assign pins.vpp_on = vpp_r;
   assign pins.port2_bit7_enable = wr_r;
   assign pins.port2_bit6_select = sel_r[2];
   assign pins.port3_bit7_select = sel_r[1];
   assign pins.port3_bit6_select = sel_r[0];
   assign pins.addr = addr_r;
   assign pins.p0_prog_out = data_r;
   assign pins.p0_prog_oe_n = ~wr_r;
endmodule // opv_programmer
`default_nettype wire

// ### verif/opv_checker.sv
// Purpose: pin checks between the programmer end and the device end
// Assumes: single ref_clk domain, rst_b async active low
// Notes: strobe widths and pulse counts measured in ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module opv_checker #(
   parameter int PULSES = 25,
   parameter int PULSE_LOW_CYC = 20,
   parameter int PULSE_HIGH_CYC = 5,
   parameter logic [7:0] SIG_ID0 = 8'hA5
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // mode pins
   input wire logic chip_reset,
   input wire logic code_fetch_enable_n,
   input wire logic latch_program_strobe,
   input wire logic external_access_prog_voltage,
   input wire logic vpp_on,
   input wire logic port2_bit7_enable,
   input wire logic port2_bit6_select,
   input wire logic port3_bit7_select,
   input wire logic port3_bit6_select,
   // address and data
   input wire logic [15:0] addr,
   input wire logic p0_dev_oe_n,
   input wire logic [7:0] port0
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   logic strobe_q;
   logic [15:0] low_cnt;
   logic [15:0] high_cnt;
   logic [7:0] fall_cnt;
   wire logic fall_seen;
   wire logic read_lv;
   wire logic sig_lv;
   assign fall_seen = strobe_q & ~latch_program_strobe;
   assign read_lv = chip_reset & ~code_fetch_enable_n & latch_program_strobe & external_access_prog_voltage
      & ~vpp_on & ~port2_bit7_enable & ~port2_bit6_select;
   assign sig_lv = read_lv & ~port3_bit7_select & ~port3_bit6_select;
   // no saturation: runs stay far below the 16-bit wrap
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         strobe_q <= 1'b1;
         low_cnt <= 16'h0000;
         high_cnt <= 16'h0000;
         fall_cnt <= 8'h00;
      end else begin
         strobe_q <= latch_program_strobe;
         low_cnt <= latch_program_strobe ? 16'h0000 : low_cnt + 16'h0001;
         high_cnt <= latch_program_strobe ? high_cnt + 16'h0001 : 16'h0000;
         fall_cnt <= vpp_on ? fall_cnt + {7'h00, fall_seen} : 8'h00;
      end
   end
   AST_DEV_RELEASE: assert property (!p0_dev_oe_n |-> $past(read_lv))
      else $error("device drove port 0 outside read levels");
   AST_SIG_DRIVE: assert property (sig_lv [*2] |-> !p0_dev_oe_n)
      else $error("signature read left port 0 undriven");
   AST_SIG_VALUE: assert property ((sig_lv && addr == opv_pkg::SIG_ADDR0) [*2] |-> port0 == SIG_ID0)
      else $error("first signature byte wrong");
   AST_WRITE_QUIET: assert property (vpp_on [*2] |-> p0_dev_oe_n)
      else $error("device drives port 0 during a write");
   AST_STROBE_QUAL: assert property (!latch_program_strobe |-> vpp_on && port2_bit7_enable)
      else $error("strobe low without write levels");
   AST_LOW_WIDTH: assert property ($rose(latch_program_strobe) |-> low_cnt == 16'(PULSE_LOW_CYC))
      else $error("strobe low width wrong");
   AST_HIGH_GAP: assert property ($fell(latch_program_strobe) |-> high_cnt >= 16'(PULSE_HIGH_CYC))
      else $error("strobe high gap too short");
   AST_PULSE_COUNT: assert property ($fell(vpp_on) |-> fall_cnt == 8'(PULSES))
      else $error("wrong number of strobe pulses");
   cover property ($fell(vpp_on));
   cover property (sig_lv [*2]);
   cover property (read_lv && port3_bit7_select && !p0_dev_oe_n);
endmodule // opv_checker
`default_nettype wire

// ### verif/test_otp_program_verify_port.sv
// Purpose: drives the programmer end against the device end
// Assumes: shortened strobe timing, small part with 25 pulses
// Notes: code store survives rst_b, table and locks do not
`timescale 1ns/1ps
`default_nettype none
module test_otp_program_verify_port;
   localparam int PULSES = 25;
   localparam int LOW = 20;
   localparam int HIGH = 5;
   // identity bytes: arbitrary values
   localparam logic [7:0] ID0 = 8'hA5;
   localparam logic [7:0] ID1 = 8'h3C;
   localparam opv_pkg::opv_op_t K_CODE = opv_pkg::OP_CODE;
   localparam opv_pkg::opv_op_t K_ENC = opv_pkg::OP_ENC;
   localparam opv_pkg::opv_op_t K_S1 = opv_pkg::OP_SEC1;
   localparam opv_pkg::opv_op_t K_S2 = opv_pkg::OP_SEC2;
   localparam opv_pkg::opv_op_t K_VER = opv_pkg::OP_VERIFY;
   localparam opv_pkg::opv_op_t K_SIG = opv_pkg::OP_SIG;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   opv_pkg::opv_op_t cmd_op = opv_pkg::OP_VERIFY;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_data = 8'h00;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic lock_bit_one;
   logic lock_bit_two;
   logic table_written;
   int error_cnt = 0;
   int checks = 0;
   opv_if opv_if_inst();
   opv_device #(.PULSES(PULSES), .SIG_ID0(ID0), .SIG_ID1(ID1)) opv_device_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .pins(opv_if_inst),
      .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two), .table_written(table_written));
   opv_programmer #(.PULSES(PULSES), .PULSE_LOW_CYC(LOW), .PULSE_HIGH_CYC(HIGH), .VPP_SETUP_CYC(5),
      .ACCESS_CYC(5)) opv_programmer_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .pins(opv_if_inst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   opv_checker #(.PULSES(PULSES), .PULSE_LOW_CYC(LOW), .PULSE_HIGH_CYC(HIGH), .SIG_ID0(ID0)) opv_checker_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .chip_reset(opv_if_inst.chip_reset),
      .code_fetch_enable_n(opv_if_inst.code_fetch_enable_n),
      .latch_program_strobe(opv_if_inst.latch_program_strobe),
      .external_access_prog_voltage(opv_if_inst.external_access_prog_voltage),
      .vpp_on(opv_if_inst.vpp_on), .port2_bit7_enable(opv_if_inst.port2_bit7_enable),
      .port2_bit6_select(opv_if_inst.port2_bit6_select), .port3_bit7_select(opv_if_inst.port3_bit7_select),
      .port3_bit6_select(opv_if_inst.port3_bit6_select), .addr(opv_if_inst.addr),
      .p0_dev_oe_n(opv_if_inst.p0_dev_oe_n), .port0(opv_if_inst.port0));
   always #4 ref_clk = ~ref_clk;
   task automatic conclude;
      if (error_cnt == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] status();
      return {5'h00, table_written, lock_bit_one, lock_bit_two};
   endfunction
   // one command, waits for ready again and, on reads, for the answer pulse
   task automatic run(input opv_pkg::opv_op_t op, input logic [15:0] a, input logic [7:0] d);
      int n;
      logic seen;
      n = 0;
      seen = (op != K_VER && op != K_SIG);
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      while ((cmd_ready !== 1'b1 || !seen) && n < 4000) begin
         @(negedge ref_clk);
         seen |= (rsp_valid === 1'b1);
         n++;
      end
      if (n >= 4000) begin
         error_cnt++;
         $display("BAD %0t command hung", $time);
      end
   endtask
   task automatic t_fresh;
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'hFF);
      chk(status(), 8'h00);
   endtask
   // second write ANDs into the cell, bits only clear
   task automatic t_code;
      run(K_CODE, 16'h0123, 8'h5A);
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'h5A);
      run(K_CODE, 16'h0123, 8'hF3);
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'h52);
   endtask
   task automatic t_table;
      run(K_ENC, 16'h0003, 8'h0F);
      run(K_ENC, 16'h001F, 8'h00);
      chk(status(), 8'h04);
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'hA2);
      run(K_VER, 16'h003F, 8'h00);
      chk(rsp_data, 8'h00);
      run(K_VER, 16'h0124, 8'h00);
      chk(rsp_data, 8'hFF);
   endtask
   task automatic t_sig;
      run(K_SIG, 16'h0030, 8'h00);
      chk(rsp_data, ID0);
      run(K_SIG, 16'h0031, 8'h00);
      chk(rsp_data, ID1);
      run(K_SIG, 16'h0003, 8'h00);
      chk(rsp_data, 8'hFF);
   endtask
   // refused code and table writes go to different entries so one cannot mask the other
   task automatic t_lock1;
      run(K_S1, 16'h0000, 8'h00);
      chk(status(), 8'h06);
      run(K_CODE, 16'h0124, 8'h00);
      run(K_ENC, 16'h0005, 8'h00);
      run(K_VER, 16'h0124, 8'h00);
      chk(rsp_data, 8'hFF);
      run(K_VER, 16'h0005, 8'h00);
      chk(rsp_data, 8'hFF);
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'hA2);
   endtask
   task automatic t_lock2;
      run(K_S2, 16'h0000, 8'h00);
      chk(status(), 8'h07);
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'hFF);
      run(K_SIG, 16'h0031, 8'h00);
      chk(rsp_data, ID1);
   endtask
   // power-up model: table and locks clear, code cells keep their charge
   task automatic t_reset;
      rst_b = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      chk(status(), 8'h00);
      run(K_VER, 16'h0123, 8'h00);
      chk(rsp_data, 8'h52);
   endtask
   initial begin
      #100000;
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      t_fresh();
      t_code();
      t_table();
      t_sig();
      t_lock1();
      t_lock2();
      t_reset();
      conclude();
   end
endmodule // test_otp_program_verify_port
`default_nettype wire
